// File: scdd_clk_src.sv
// sample clock source and alignment pulse driver facing the divider
`timescale 1ns/10ps
module scdd_clk_src #(
  parameter int HIGH_NS = 125, // high time of the sample clock
  parameter int LOW_NS = 225 // low time, uneven on purpose
) (
  input wire logic run_i, // clock applied while high
  input wire logic sync_req_i, // request one alignment pulse
  output logic samp_clk_o, // sample clock pin
  output logic sync_o // alignment pin
);
  // clock held low until run, so the ratio is set first
  initial begin
    samp_clk_o = 1'b0;
    forever begin
      #(LOW_NS);
      samp_clk_o = run_i;
      #(HIGH_NS);
      samp_clk_o = 1'b0;
    end
  end
  // one pulse of eight system cycles per request
  initial begin
    sync_o = 1'b0;
    forever begin
      @(posedge sync_req_i);
      sync_o = 1'b1;
      #200;
      sync_o = 1'b0;
    end
  end
endmodule : scdd_clk_src

// File: scdd_pkg.sv
// constants, types and the behaviour summary of the sample clock divider and delay block
// Operation
// - divide input clock by 1, 2, 4 or 8
// - divided clock keeps fifty percent duty cycle for ratios 2, 4 and 8; ratio 1 passes the input duty
// - enabled alignment pulse presets divider to programmed state
// - alignment input obeyed only while enable bit set
// - per channel half input cycle phase delay
// - enable bit turns fine edge adjustment on
// - eight bit fine delay value per channel
// - fine delay spans minus 151.7 to 150 ps
// - fine delay applies at once on write
// - fine delay enable write resets sample datapath
// - samples taken on divided delayed clock rising edge
package scdd_pkg;
  // serial port frame: read flag, 15 bit address, 8 bit data
  localparam int SCDD_AW = 15;
  localparam logic [4:0] SCDD_FRAME_BITS = 5'd24;
  localparam logic [4:0] SCDD_ADDR_BITS = 5'd16;
  // register offsets
  localparam logic [14:0] SCDD_ADDR_INDEX = 15'h008;
  localparam logic [14:0] SCDD_ADDR_RATIO = 15'h10b;
  localparam logic [14:0] SCDD_ADDR_HALF = 15'h10c;
  localparam logic [14:0] SCDD_ADDR_SYNC = 15'h10d;
  localparam logic [14:0] SCDD_ADDR_FCTL = 15'h117;
  localparam logic [14:0] SCDD_ADDR_FVAL = 15'h118;
  // field positions
  localparam int SCDD_SYNC_EN_BIT = 7;
  localparam int SCDD_SYNC_SEEN_BIT = 6;
  localparam int SCDD_HALF_EN_BIT = 0;
  localparam int SCDD_FINE_EN_BIT = 0;
  // reset values
  localparam logic [1:0] SCDD_INDEX_RST = 2'h3;
  localparam logic [1:0] SCDD_RATIO_RST = 2'h0;
  localparam logic [2:0] SCDD_PRESET_RST = 3'h0;
  localparam logic [7:0] SCDD_FVAL_RST = 8'h00;
  // fine delay in tenths of a picosecond
  localparam logic signed [13:0] SCDD_FDLY_MIN_X10 = -14'sd1517;
  localparam logic signed [13:0] SCDD_FDLY_STEP_X10 = 14'sd17;
  localparam logic signed [13:0] SCDD_FDLY_MAX_X10 = 14'sd1500;
  // serial port states, gray along idle, transfer, done
  typedef enum logic [1:0] {
    SCDD_SP_IDLE = 2'b00,
    SCDD_SP_XFER = 2'b01,
    SCDD_SP_DONE = 2'b11
  } scdd_sp_state_t;
  // per channel delay settings
  typedef struct packed {
    logic half_en;
    logic fine_en;
    logic [7:0] fine_code;
  } scdd_chan_cfg_t;
endpackage : scdd_pkg

// File: scdd_top.sv
// sample clock divider, half cycle and fine delay with serial port registers
`timescale 1ns/10ps
module scdd_top
  import scdd_pkg::*;
(
  input wire logic clk_i, // 40 mhz system clock
  input wire logic rst_b_i, // synchronous reset, active low
  input wire logic samp_clk_i, // incoming sample clock pin
  input wire logic sync_i, // external alignment pin
  input wire logic spi_csb_b_i, // serial port select, active low
  input wire logic spi_sclk_i, // serial port clock
  input wire logic spi_sdio_i, // serial data in
  output logic spi_sdio_o, // serial data out
  output logic spi_sdio_oe_o, // high while driving serial data
  output logic [1:0] conv_clk_o, // divided delayed clock per channel
  output logic [1:0] samp_stb_o, // one pulse per sampling edge
  output scdd_chan_cfg_t [1:0] chan_cfg_o, // delay settings per channel
  output logic signed [13:0] fine_ps_a_o, // channel a fine delay, 0.1 ps
  output logic signed [13:0] fine_ps_b_o, // channel b fine delay, 0.1 ps
  output logic dp_rst_o // datapath reset pulse
);
  // fine delay code to tenths of a picosecond, clipped at top
  function automatic logic signed [13:0] scdd_ps(input logic [7:0] c);
    logic signed [13:0] v;
    v = SCDD_FDLY_MIN_X10 + $signed({6'h00, c}) * SCDD_FDLY_STEP_X10;
    if (v > SCDD_FDLY_MAX_X10) begin
      v = SCDD_FDLY_MAX_X10;
    end
    return v;
  endfunction : scdd_ps

  // pin synchronisers: stage 1, stage 2, and a history stage for edges
  logic [3:0] s1, s2, s3; // bit0 clk, bit1 sync, bit2 csb, bit3 sclk
  logic sdi1, sdi2; // data in synchroniser
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s1 <= 4'h4;
      s2 <= 4'h4;
      s3 <= 4'h4;
      sdi1 <= 1'b0;
      sdi2 <= 1'b0;
    end else begin
      s1 <= {spi_sclk_i, spi_csb_b_i, sync_i, samp_clk_i};
      s2 <= s1;
      s3 <= s2;
      sdi1 <= spi_sdio_i;
      sdi2 <= sdi1;
    end
  end
  logic clk_rise, clk_edge, sync_rise, sclk_rise, csb_hi; // decoded pin events
  assign clk_rise = s2[0] & ~s3[0];
  assign clk_edge = s2[0] ^ s3[0];
  assign sync_rise = s2[1] & ~s3[1];
  assign csb_hi = s2[2];
  assign sclk_rise = s2[3] & ~s3[3];

  // ---- serial port and registers ----
  scdd_sp_state_t sp_st, next_sp_st; // frame state
  logic [4:0] bit_cnt, next_bit_cnt; // bits taken in frame
  logic [22:0] shin, next_shin; // shifted-in flag and address
  logic [7:0] tx, next_tx; // read data being shifted out
  logic rd_fr, next_rd_fr; // frame is a read
  logic [1:0] idx, next_idx; // channel select for local registers
  logic [1:0] ratio, next_ratio; // divide ratio code
  logic sync_en, next_sync_en; // alignment enable
  logic sync_seen, next_sync_seen; // sticky alignment seen
  logic [2:0] preset, next_preset; // divider state loaded on alignment
  scdd_chan_cfg_t [1:0] cfg, next_cfg; // per channel settings
  logic dprst, next_dprst; // datapath reset pulse
  logic wr_go; // a write frame completes this cycle
  logic [14:0] wr_addr; // address of completing write
  logic [7:0] wr_data; // data of completing write
  logic [7:0] rd_data; // read mux
  logic sync_hit; // alignment accepted this cycle
  logic wr_fctl; // fine control write completes

  assign wr_go = (sp_st == SCDD_SP_XFER) && sclk_rise && !csb_hi && !shin[22]
                 && (bit_cnt == SCDD_FRAME_BITS - 5'd1);
  assign wr_addr = shin[21:7];
  assign wr_data = {shin[6:0], sdi2};
  assign wr_fctl = wr_go && (wr_addr == SCDD_ADDR_FCTL);
  assign sync_hit = sync_rise && sync_en;

  // read mux, local registers read from channel a unless only b selected
  always_comb begin
    logic ch;
    ch = (idx == 2'h2);
    rd_data = 8'h00;
    // address is the fifteen bits ending with the bit taken this cycle
    case ({shin[13:0], sdi2})
      SCDD_ADDR_INDEX: rd_data = {6'h00, idx};
      SCDD_ADDR_RATIO: rd_data = {6'h00, ratio};
      SCDD_ADDR_HALF: rd_data = {7'h00, cfg[ch].half_en};
      SCDD_ADDR_SYNC: rd_data = {sync_en, sync_seen, 3'h0, preset};
      SCDD_ADDR_FCTL: rd_data = {7'h00, cfg[ch].fine_en};
      SCDD_ADDR_FVAL: rd_data = cfg[ch].fine_code;
      default: rd_data = 8'h00;
    endcase
  end

  // next values of serial port and registers
  always_comb begin
    next_sp_st = sp_st;
    next_bit_cnt = bit_cnt;
    next_shin = shin;
    next_tx = tx;
    next_rd_fr = rd_fr;
    next_idx = idx;
    next_ratio = ratio;
    next_sync_en = sync_en;
    next_preset = preset;
    next_cfg = cfg;
    next_dprst = 1'b0;
    next_sync_seen = sync_seen;
    if (csb_hi) begin // select high ends any frame
      next_sp_st = SCDD_SP_IDLE;
      next_bit_cnt = 5'd0;
      next_rd_fr = 1'b0;
    end else begin
      case (sp_st)
        SCDD_SP_IDLE: begin
          next_sp_st = SCDD_SP_XFER;
        end
        SCDD_SP_XFER: begin
          if (sclk_rise) begin
            next_bit_cnt = bit_cnt + 5'd1;
            next_shin = {shin[21:0], sdi2};
            if (rd_fr) begin
              next_tx = {tx[6:0], 1'b0};
            end
            if (bit_cnt == SCDD_ADDR_BITS - 5'd1 && shin[14]) begin
              next_rd_fr = 1'b1;
              next_tx = rd_data;
            end
            if (bit_cnt == SCDD_FRAME_BITS - 5'd1) begin
              next_sp_st = SCDD_SP_DONE;
              next_rd_fr = 1'b0;
            end
          end
        end
        SCDD_SP_DONE: begin
          next_sp_st = SCDD_SP_DONE;
        end
        default: begin
          next_sp_st = SCDD_SP_IDLE;
        end
      endcase
    end
    if (wr_go) begin // register writes apply at once
      case (wr_addr)
        SCDD_ADDR_INDEX: next_idx = wr_data[1:0];
        SCDD_ADDR_RATIO: next_ratio = wr_data[1:0];
        SCDD_ADDR_SYNC: begin
          next_sync_en = wr_data[SCDD_SYNC_EN_BIT];
          next_preset = wr_data[2:0];
          next_sync_seen = 1'b0;
        end
        default: begin
        end
      endcase
      for (int c = 0; c < 2; c++) begin
        if (idx[c]) begin
          if (wr_addr == SCDD_ADDR_HALF) next_cfg[c].half_en = wr_data[SCDD_HALF_EN_BIT];
          if (wr_addr == SCDD_ADDR_FCTL) next_cfg[c].fine_en = wr_data[SCDD_FINE_EN_BIT];
          if (wr_addr == SCDD_ADDR_FVAL) next_cfg[c].fine_code = wr_data;
        end
      end
      next_dprst = wr_fctl && wr_data[SCDD_FINE_EN_BIT];
    end
    if (sync_hit) begin // set wins over the clearing write
      next_sync_seen = 1'b1;
    end
  end

  // register the serial port and register file
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sp_st <= SCDD_SP_IDLE;
      bit_cnt <= 5'd0;
      shin <= 23'h000000;
      tx <= 8'h00;
      rd_fr <= 1'b0;
      idx <= SCDD_INDEX_RST;
      ratio <= SCDD_RATIO_RST;
      sync_en <= 1'b0;
      sync_seen <= 1'b0;
      preset <= SCDD_PRESET_RST;
      cfg <= {2{1'b0, 1'b0, SCDD_FVAL_RST}};
      dprst <= 1'b0;
    end else begin
      sp_st <= next_sp_st;
      bit_cnt <= next_bit_cnt;
      shin <= next_shin;
      tx <= next_tx;
      rd_fr <= next_rd_fr;
      idx <= next_idx;
      ratio <= next_ratio;
      sync_en <= next_sync_en;
      sync_seen <= next_sync_seen;
      preset <= next_preset;
      cfg <= next_cfg;
      dprst <= next_dprst;
    end
  end

  // ---- divider and delay ----
  logic [2:0] rcnt, next_rcnt; // rising edges of input clock
  logic und; // divided clock before half cycle delay
  logic [1:0] hd, next_hd; // half cycle delayed copy
  logic [1:0] conv, next_conv; // channel clocks
  logic [1:0] stb, next_stb; // sampling edge pulses

  // undelayed clock: level for ratio 1, else a counter bit flipping on rises
  assign und = (ratio == 2'h0) ? s3[0] : rcnt[ratio - 2'h1];

  // next divider and channel clock values
  always_comb begin
    next_rcnt = rcnt;
    if (sync_hit) begin
      next_rcnt = preset;
    end else if (clk_rise) begin
      next_rcnt = rcnt + 3'h1;
    end
    for (int c = 0; c < 2; c++) begin
      next_hd[c] = clk_edge ? und : hd[c];
      next_conv[c] = cfg[c].half_en ? next_hd[c] : und;
      next_stb[c] = next_conv[c] & ~conv[c];
    end
  end

  // register divider state
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rcnt <= 3'h0;
      hd <= 2'h0;
      conv <= 2'h0;
      stb <= 2'h0;
    end else begin
      rcnt <= next_rcnt;
      hd <= next_hd;
      conv <= next_conv;
      stb <= next_stb;
    end
  end

  assign conv_clk_o = conv;
  assign samp_stb_o = stb;
  assign chan_cfg_o = cfg;
  assign fine_ps_a_o = scdd_ps(cfg[0].fine_code);
  assign fine_ps_b_o = scdd_ps(cfg[1].fine_code);
  assign dp_rst_o = dprst;
  assign spi_sdio_o = tx[7];
  assign spi_sdio_oe_o = rd_fr && !csb_hi;

  // ---- checks ----
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  AST_DIV_COUNT: assert property (clk_rise && !sync_hit |=> rcnt == $past(rcnt) + 3'h1)
    else $error("divider missed an input rise");
  AST_SYNC_LOAD: assert property (sync_rise && sync_en |=> rcnt == $past(preset))
    else $error("alignment did not load preset");
  AST_SYNC_GATE: assert property (!sync_en && !clk_rise |=> rcnt == $past(rcnt))
    else $error("divider moved without rise or enabled alignment");
  AST_DUTY: assert property (ratio != 2'h0 && !clk_rise && !sync_hit && !wr_go |=> $stable(und))
    else $error("divided clock changed away from an input rise");
  AST_HALF: assert property (clk_edge && cfg[0].half_en |=> conv[0] == $past(und))
    else $error("half cycle delay not applied");
  AST_HALF_B: assert property (clk_edge && cfg[1].half_en |=> conv[1] == $past(und))
    else $error("channel b half cycle delay not applied");
  AST_PASS: assert property (ratio == 2'h0 && !cfg[0].half_en |=> conv[0] == $past(s3[0]))
    else $error("ratio one did not pass the clock");
  AST_FINE_EN: assert property (wr_fctl && idx[0] |=> cfg[0].fine_en == $past(wr_data[0]))
    else $error("fine enable write not applied");
  AST_FINE_VAL: assert property (wr_go && wr_addr == SCDD_ADDR_FVAL && idx[1]
    |=> cfg[1].fine_code == $past(wr_data))
    else $error("fine value write not applied");
  AST_RANGE: assert property (fine_ps_a_o >= SCDD_FDLY_MIN_X10 && fine_ps_a_o <= SCDD_FDLY_MAX_X10)
    else $error("fine delay out of range");
  AST_DPRST: assert property (wr_fctl && wr_data[0] |=> dp_rst_o ##1 !dp_rst_o)
    else $error("datapath reset not a single pulse");
  AST_STB: assert property (samp_stb_o[0] |-> conv_clk_o[0] && !$past(conv_clk_o[0]))
    else $error("sample pulse not on a rising edge");
endmodule : scdd_top

// File: test_scdd_top.sv
// self-checking bench for the sample clock divider and delay block
`timescale 1ns/10ps
module test_scdd_top;
  import scdd_pkg::*;
  logic clk_i, rst_b_i, run, sreq, samp_clk, sync, csb, sclk, sdi, oe;
  logic spi_sdio_o, spi_sdio_oe_o, dp_rst_o;
  logic [1:0] conv_clk_o, samp_stb_o;
  scdd_chan_cfg_t [1:0] chan_cfg_o; // per channel delay settings
  logic signed [13:0] fine_ps_a_o, fine_ps_b_o;
  logic [7:0] rd; // last read byte
  int error_cnt = 0, compares = 0, cyc = 0, dp_cnt = 0, stb_cnt = 0;
  int hi, lo, lag, s0;
  logic [14:0] ra[6] = '{SCDD_ADDR_RATIO, SCDD_ADDR_HALF, SCDD_ADDR_SYNC,
                         SCDD_ADDR_FCTL, SCDD_ADDR_FVAL, 15'h7ff};
  logic [7:0] fc[5] = '{8'h00, 8'h01, 8'hb1, 8'hb2, 8'hff};

  scdd_top dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .samp_clk_i(samp_clk), .sync_i(sync),
    .spi_csb_b_i(csb), .spi_sclk_i(sclk), .spi_sdio_i(sdi), .spi_sdio_o(spi_sdio_o),
    .spi_sdio_oe_o(spi_sdio_oe_o), .conv_clk_o(conv_clk_o), .samp_stb_o(samp_stb_o),
    .chan_cfg_o(chan_cfg_o), .fine_ps_a_o(fine_ps_a_o), .fine_ps_b_o(fine_ps_b_o),
    .dp_rst_o(dp_rst_o));
  scdd_clk_src src (.run_i(run), .sync_req_i(sreq), .samp_clk_o(samp_clk), .sync_o(sync));

  // 40 mhz clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // pulse counters and hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (dp_rst_o === 1'b1) dp_cnt <= dp_cnt + 1;
    if (samp_stb_o === 2'h3) stb_cnt <= stb_cnt + 1; // both channels pulse together
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask : tick
  // one serial frame, msb first, sclk half period of six cycles
  task automatic spi(input logic r, input logic [14:0] a, input logic [7:0] d);
    logic [23:0] f;
    f = {r, a, d};
    csb = 1'b0;
    for (int k = 23; k >= 0; k--) begin
      sdi = f[k];
      tick(6);
      if (k < 8) rd[k] = spi_sdio_o;
      if (k == 7) oe = spi_sdio_oe_o;
      sclk = 1'b1;
      tick(6);
      sclk = 1'b0;
    end
    csb = 1'b1;
    tick(8);
  endtask : spi
  task automatic wait_a(input logic v);
    int n;
    n = 0;
    while (conv_clk_o[0] !== v && n < 400) begin
      tick(1);
      n++;
    end
    if (n == 400) chk("conv wait", 16'h0, 16'h1);
  endtask : wait_a
  // expected fine delay in tenths of a picosecond
  function automatic logic signed [13:0] fexp(input logic [7:0] c);
    int v;
    v = -1517 + 17 * int'(c);
    return 14'(v > 1500 ? 1500 : v);
  endfunction : fexp

  initial begin
    rst_b_i = 1'b0;
    run = 1'b0;
    sreq = 1'b0;
    csb = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
    tick(6);
    rst_b_i = 1'b1;
    tick(8);
    // reset values and an unmapped read
    foreach (ra[i]) begin
      spi(1'b1, ra[i], 8'h00);
      chk("reset reg", {8'h00, rd}, 16'h0000);
    end
    chk("sdio drive", {15'h0, oe}, 16'h1);
    $display("test reset done");
    // alignment only while enabled, clock still stopped
    spi(1'b0, SCDD_ADDR_RATIO, 8'h03);
    spi(1'b0, SCDD_ADDR_SYNC, 8'h04);
    sreq = 1'b1;
    tick(1);
    sreq = 1'b0;
    tick(12);
    chk("sync off", {14'h0, conv_clk_o}, 16'h0);
    spi(1'b0, SCDD_ADDR_SYNC, 8'h84);
    sreq = 1'b1;
    tick(1);
    sreq = 1'b0;
    tick(12);
    chk("sync on", {14'h0, conv_clk_o}, 16'h3);
    spi(1'b1, SCDD_ADDR_SYNC, 8'h00);
    chk("sync reg", {8'h00, rd}, 16'hc4);
    $display("test align done");
    // every ratio: period, duty and one strobe per output cycle
    for (int c = 0; c < 4; c++) begin
      run = 1'b0;
      tick(40);
      spi(1'b0, SCDD_ADDR_RATIO, 8'(c));
      run = 1'b1;
      wait_a(1'b0);
      wait_a(1'b1);
      chk("b follows a", {15'h0, conv_clk_o[1]}, 16'h1);
      hi = 0;
      lo = 0;
      s0 = stb_cnt;
      while (conv_clk_o[0] === 1'b1 && hi < 200) begin
        tick(1);
        hi++;
      end
      while (conv_clk_o[0] === 1'b0 && lo < 200) begin
        tick(1);
        lo++;
      end
      chk("period", 16'(hi + lo), 16'(14 << c));
      if (c == 0) chk("pass high", 16'(hi), 16'd5);
      else chk("duty", 16'(hi), 16'(lo));
      chk("strobes", 16'(stb_cnt - s0), 16'd1);
    end
    $display("test ratio done");
    // half cycle delay on channel b only
    spi(1'b0, SCDD_ADDR_INDEX, 8'h02);
    spi(1'b0, SCDD_ADDR_HALF, 8'h01);
    chk("half b", {15'h0, chan_cfg_o[1].half_en}, 16'h1);
    chk("half a", {15'h0, chan_cfg_o[0].half_en}, 16'h0);
    wait_a(1'b0);
    wait_a(1'b1);
    lag = 0;
    while (conv_clk_o[1] !== 1'b1 && lag < 30) begin
      tick(1);
      lag++;
    end
    chk("half lag", 16'(lag > 0 && lag < 14), 16'h1);
    $display("test half done");
    // fine delay on channel a, datapath reset on enable
    spi(1'b0, SCDD_ADDR_INDEX, 8'h01);
    s0 = dp_cnt;
    spi(1'b0, SCDD_ADDR_FCTL, 8'h01);
    chk("dp pulses", 16'(dp_cnt - s0), 16'd1);
    chk("fine on", {15'h0, chan_cfg_o[0].fine_en}, 16'h1);
    foreach (fc[i]) begin
      spi(1'b0, SCDD_ADDR_FVAL, fc[i]);
      chk("fine code", {8'h00, chan_cfg_o[0].fine_code}, {8'h00, fc[i]});
      chk("fine ps", 16'(fine_ps_a_o), 16'(fexp(fc[i])));
    end
    chk("fine ps b", 16'(fine_ps_b_o), 16'(fexp(8'h00)));
    spi(1'b0, SCDD_ADDR_INDEX, 8'h02);
    spi(1'b0, SCDD_ADDR_FVAL, 8'h5a);
    chk("fine code b", {8'h00, chan_cfg_o[1].fine_code}, 16'h005a);
    chk("fine code a kept", {8'h00, chan_cfg_o[0].fine_code}, 16'h00ff);
    chk("fine ps b set", 16'(fine_ps_b_o), 16'(fexp(8'h5a)));
    spi(1'b0, SCDD_ADDR_INDEX, 8'h01);
    s0 = dp_cnt;
    spi(1'b0, SCDD_ADDR_FCTL, 8'h00);
    chk("dp none", 16'(dp_cnt - s0), 16'd0);
    chk("fine off", {15'h0, chan_cfg_o[0].fine_en}, 16'h0);
    $display("test fine done");
    end_sim();
  end
endmodule : test_scdd_top
